// >>> mcd_engine.sv
// Eight-channel descriptor-driven copy engine, top level.
// Assumes the ring setup and the largest packet length are stable while
// channels run, and that fetched descriptors return in request order.
// Operation
// - Eight concurrent channels, each with own ring.
// - Descriptors of a channel run in order.
// - Channels are granted in round-robin order.
// - Addresses and lengths are whole 64-byte lines.
// - Transactions carry 64 to 256 bytes, per setting.
// - Completion can raise an interrupt.
// - Completion can write a tag, local or host.
// - Addresses are physical, never translated.
// - Three directions: local-host, host-local, local-local.
// - Descriptor holds source, target, length in lines.
// - Whole engine runs on the core clock.
// - Each channel prefetches one descriptor at a time into a 64-entry queue.
// - Out-of-range head index writes flag an error.
// - Ring pointer top bit selects host memory.
`timescale 1ns/100ps
`default_nettype none

module mcd_engine
(
    input  wire logic                  i_ref_clk,   // Core clock.
    input  wire logic                  i_rstn,      // Sync reset, low.
    input  wire mcd_pkg::mcd_ring_cfg_t [mcd_pkg::NUM_CH-1:0] i_ring_cfg,
    input  wire logic [1:0]            i_pkt_len,   // Largest packet.
    input  wire mcd_pkg::mcd_head_wr_t i_head_wr,   // Head index write.
    output logic                       o_fetch_valid, // Fetch offered.
    input  wire logic                  i_fetch_ready, // Fetch accepted.
    output mcd_pkg::mcd_fetch_t        o_fetch,     // Fetch request.
    input  wire logic                  i_desc_valid, // Descriptor back.
    input  wire mcd_pkg::mcd_desc_t    i_desc,      // Fetched descriptor.
    output logic                       o_xfer_valid, // Transaction ready.
    input  wire logic                  i_xfer_ready, // Receiver takes it.
    output mcd_pkg::mcd_xfer_t         o_xfer,      // Transaction.
    output mcd_pkg::mcd_cmpl_t         o_cmpl,      // Completion pulse.
    output logic [mcd_pkg::NUM_CH-1:0] o_head_err   // Bad head, pulse.
);
    import mcd_pkg::*;

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        mcd_state_t                         st;     // Sequencer.
        logic [CH_W-1:0]                    ch;     // Channel served.
        logic [CH_W-1:0]                    last;   // Last grant.
        logic                               fsent;  // Fetch accepted.
        mcd_fetch_t                         fetch;  // Fetch request.
        mcd_desc_t                          cur;    // Descriptor in work.
        logic [NUM_CH-1:0][IDX_W-1:0]       head;   // Software head.
        logic [NUM_CH-1:0][IDX_W-1:0]       tail;   // Engine tail.
        logic [NUM_CH-1:0][QCNT_W-1:0]      cnt;    // Queue fill.
        logic [NUM_CH-1:0][QPTR_W-1:0]      rd;     // Queue read index.
        logic [NUM_CH-1:0][QPTR_W-1:0]      wr;     // Queue write index.
        mcd_desc_t [NUM_CH-1:0][QDEPTH-1:0] qd;     // Local queues.
        logic [NUM_CH-1:0]                  err;    // Head error pulse.
        mcd_cmpl_t                          cmpl;   // Completion pulse.
    } mcd_eng_st_t;

    localparam logic [QCNT_W-1:0] QFULL = QCNT_W'(QDEPTH);

    mcd_eng_st_t        q;          // Registered state.
    mcd_eng_st_t        d;          // Next state.
    logic [NUM_CH-1:0]  req;        // Channel has work.
    logic [CH_W-1:0]    grant;      // Round-robin winner.
    logic [CHUNK_W-1:0] maxl;       // Lines per transaction.
    logic [CHUNK_W-1:0] chunk;      // Lines in next transaction.
    logic               push_v;     // Engine offers a transaction.
    logic               push_rdy;   // Buffer has room.
    mcd_xfer_t          push_x;     // Transaction offered.
    logic [LINE_W-1:0]  src_step;   // Source after this transaction.
    logic               head_bad;   // Head write out of range.

    // ****************************************************************
    // Request and arbitration
    // ****************************************************************
    // A channel wants service when it holds queued descriptors, or when
    // its ring has unfetched entries and its queue has room.
    genvar gc;
    generate
        for (gc = 0; gc < NUM_CH; gc++)
        begin : g_req
            assign req[gc] = (q.cnt[gc] != '0)
                || (q.tail[gc] != q.head[gc] && q.cnt[gc] < QFULL);
        end
    endgenerate

    // Search from the channel after the last grant; the downward loop
    // leaves the nearest requester in grant.
    always_comb
    begin
        logic [CH_W-1:0] c;
        c     = '0;
        grant = q.last;
        for (int k = NUM_CH; k >= 1; k--)
        begin
            c = CH_W'(int'(q.last) + k);
            if (req[c])
            begin
                grant = c;
            end
        end
    end

    // ****************************************************************
    // Transaction sizing
    // ****************************************************************
    // Reserved settings fall back to the largest size.
    always_comb
    begin
        case (i_pkt_len)
            PKT_64:  maxl = LINES_64;
            PKT_128: maxl = LINES_128;
            default: maxl = LINES_256;
        endcase
    end

    // The last piece of a transfer may be shorter than the setting.
    assign chunk = (q.cur.lines < LEN_W'(maxl)) ?
                   q.cur.lines[CHUNK_W-1:0] : maxl;
    assign src_step = q.cur.src + LINE_W'(chunk);
    assign push_v   = (q.st == MCD_MOVE) && (q.cur.lines != '0);

    // Addresses go out exactly as the descriptor gave them.
    always_comb
    begin
        push_x.ch    = q.ch;
        push_x.dir   = q.cur.dir;
        push_x.src   = q.cur.src;
        push_x.dst   = q.cur.dst;
        push_x.lines = chunk;
    end

    assign head_bad = i_head_wr.valid
        && (i_head_wr.idx >= i_ring_cfg[i_head_wr.ch].size);

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    // One channel is served at a time; a grant lasts one fetch or one
    // whole descriptor, which bounds the wait of any other channel.
    always_comb
    begin
        d            = q;
        d.err        = '0;
        d.cmpl.valid = 1'b0;
        // Head writes are range checked before they are taken.
        if (i_head_wr.valid)
        begin
            if (head_bad)
            begin
                d.err[i_head_wr.ch] = 1'b1;
            end
            else
            begin
                d.head[i_head_wr.ch] = i_head_wr.idx;
            end
        end
        case (q.st)
            MCD_IDLE:
            begin
                if (|req)
                begin
                    d.ch   = grant;
                    d.last = grant;
                    if (q.cnt[grant] != '0)
                    begin
                        // Oldest queued descriptor first.
                        d.cur = q.qd[grant][q.rd[grant]];
                        d.rd[grant]  = q.rd[grant] + 1'b1;
                        d.cnt[grant] = q.cnt[grant] - 1'b1;
                        d.st  = MCD_MOVE;
                    end
                    else
                    begin
                        d.fetch.ch   = grant;
                        d.fetch.addr = i_ring_cfg[grant].base
                            + (ADDR_W'(q.tail[grant]) << DESC_SHIFT);
                        d.fetch.sys  =
                            i_ring_cfg[grant].base[SYS_BIT];
                        d.fsent = 1'b0;
                        d.st    = MCD_FETCH;
                    end
                end
            end
            MCD_FETCH:
            begin
                if (!q.fsent && i_fetch_ready)
                begin
                    d.fsent = 1'b1;
                end
                if (q.fsent && i_desc_valid)
                begin
                    // Queue it and advance the tail around the ring.
                    d.qd[q.ch][q.wr[q.ch]] = i_desc;
                    d.wr[q.ch]  = q.wr[q.ch] + 1'b1;
                    d.cnt[q.ch] = q.cnt[q.ch] + 1'b1;
                    d.tail[q.ch] =
                        (q.tail[q.ch] + 1'b1 == i_ring_cfg[q.ch].size) ?
                        '0 : q.tail[q.ch] + 1'b1;
                    d.st = MCD_IDLE;
                end
            end
            MCD_MOVE:
            begin
                if (q.cur.lines == '0)
                begin
                    d.st = MCD_DONE;
                end
                else if (push_rdy)
                begin
                    // Ascending pieces of whole lines.
                    d.cur.src   = src_step;
                    d.cur.dst   = q.cur.dst + LINE_W'(chunk);
                    d.cur.lines = q.cur.lines - LEN_W'(chunk);
                end
            end
            MCD_DONE:
            begin
                d.cmpl.valid    = 1'b1;
                d.cmpl.ch       = q.ch;
                d.cmpl.irq      = q.cur.irq_en;
                d.cmpl.tag_en   = q.cur.tag_en;
                d.cmpl.tag_sys  = q.cur.tag_sys;
                d.cmpl.tag_line = q.cur.tag_line;
                d.st            = MCD_IDLE;
            end
            default:
            begin
                d.st = MCD_IDLE;
            end
        endcase
    end

    // State register, all on the core clock.
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rstn)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    // ****************************************************************
    // Output buffer and outputs
    // ****************************************************************
    // A stall by the receiver holds the engine in the move state.
    mcd_buf2 u_buf
    (
        .i_ref_clk (i_ref_clk),
        .i_rstn    (i_rstn),
        .i_valid   (push_v),
        .o_ready   (push_rdy),
        .i_data    (push_x),
        .o_valid   (o_xfer_valid),
        .i_ready   (i_xfer_ready),
        .o_data    (o_xfer)
    );

    assign o_fetch_valid = (q.st == MCD_FETCH) && !q.fsent;
    assign o_fetch       = q.fetch;
    assign o_cmpl        = q.cmpl;
    assign o_head_err    = q.err;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rstn);

    chunk_size_a: assert property (push_v && push_rdy |->
        push_x.lines != '0 && push_x.lines <= maxl)
        else $error("transaction size outside the setting");

    xfer_order_a: assert property (push_v && push_rdy
        |=> q.cur.src == $past(src_step))
        else $error("source did not advance by the piece sent");

    head_err_a: assert property (head_bad
        |=> o_head_err[$past(i_head_wr.ch)])
        else $error("bad head index not flagged");

    head_ok_a: assert property (i_head_wr.valid && !head_bad
        |=> o_head_err == '0 && q.head[$past(i_head_wr.ch)]
            == $past(i_head_wr.idx))
        else $error("good head index refused");

    fetch_sys_a: assert property (o_fetch_valid |->
        o_fetch.sys == i_ring_cfg[o_fetch.ch].base[SYS_BIT])
        else $error("fetch memory select wrong");

    rr_turn_a: assert property (q.st == MCD_IDLE
        && req[CH_W'(q.last + 1'b1)]
        |=> q.ch == CH_W'($past(q.last) + 1'b1))
        else $error("next channel skipped");

    queue_cap_a: assert property (q.cnt[q.ch] <= QFULL)
        else $error("queue over capacity");

    done_seq_a: assert property (q.st == MCD_MOVE
        && q.cur.lines == '0 |=> ##1 o_cmpl.valid ##1 !o_cmpl.valid)
        else $error("completion not one pulse after the move");

endmodule : mcd_engine

`default_nettype wire

// >>> mcd_pkg.sv
// Shared constants and carrier types of the eight-channel descriptor
// engine. Assumes nothing; every other file of the engine imports it.
`default_nettype none

package mcd_pkg;

    // ****************************************************************
    // Sizes and positions
    // ****************************************************************
    localparam int NUM_CH     = 8;   // Concurrent channels.
    localparam int CH_W       = 3;   // Channel number width.
    localparam int QDEPTH     = 64;  // Prefetched descriptors per channel.
    localparam int QPTR_W     = 6;   // Queue pointer width.
    localparam int QCNT_W     = 7;   // Queue fill count width.
    localparam int IDX_W      = 17;  // Ring index width, up to 128K entries.
    localparam int ADDR_W     = 40;  // Physical address width.
    localparam int LINE_SHIFT = 6;   // A cache line is 64 bytes.
    localparam int LINE_W     = ADDR_W - LINE_SHIFT;
    localparam int DESC_SHIFT = 4;   // A descriptor is 16 bytes.
    localparam int SYS_BIT    = ADDR_W - 1;  // Set: host system memory.
    localparam int LEN_W      = 20;  // Transfer length in cache lines.
    localparam int CHUNK_W    = 3;   // Lines in one transaction.

    // ****************************************************************
    // Largest packet length setting and its size in lines
    // ****************************************************************
    localparam logic [1:0]         PKT_64    = 2'h0;
    localparam logic [1:0]         PKT_128   = 2'h1;
    localparam logic [CHUNK_W-1:0] LINES_64  = 3'h1;
    localparam logic [CHUNK_W-1:0] LINES_128 = 3'h2;
    localparam logic [CHUNK_W-1:0] LINES_256 = 3'h4;

    // ****************************************************************
    // Types
    // ****************************************************************
    // Direction of a copy.
    typedef enum logic [1:0] {
        MCD_DIR_L2H,
        MCD_DIR_H2L,
        MCD_DIR_L2L
    } mcd_dir_t;

    // Engine sequencing states.
    typedef enum logic [1:0] {
        MCD_IDLE,
        MCD_FETCH,
        MCD_MOVE,
        MCD_DONE
    } mcd_state_t;

    // One descriptor as returned by a ring fetch; addresses in lines.
    typedef struct packed {
        logic [LINE_W-1:0] src;
        logic [LINE_W-1:0] dst;
        logic [LEN_W-1:0]  lines;
        mcd_dir_t          dir;
        logic              irq_en;
        logic              tag_en;
        logic              tag_sys;
        logic [LINE_W-1:0] tag_line;
    } mcd_desc_t;

    // Per-channel ring setup.
    typedef struct packed {
        logic [ADDR_W-1:0] base;
        logic [IDX_W-1:0]  size;
    } mcd_ring_cfg_t;

    // Software head index update.
    typedef struct packed {
        logic             valid;
        logic [CH_W-1:0]  ch;
        logic [IDX_W-1:0] idx;
    } mcd_head_wr_t;

    // Descriptor fetch request.
    typedef struct packed {
        logic [CH_W-1:0]   ch;
        logic [ADDR_W-1:0] addr;
        logic              sys;
    } mcd_fetch_t;

    // One data transaction toward the link or the memory ring.
    typedef struct packed {
        logic [CH_W-1:0]    ch;
        mcd_dir_t           dir;
        logic [LINE_W-1:0]  src;
        logic [LINE_W-1:0]  dst;
        logic [CHUNK_W-1:0] lines;
    } mcd_xfer_t;

    // Completion notice with interrupt and tag write request.
    typedef struct packed {
        logic              valid;
        logic [CH_W-1:0]   ch;
        logic              irq;
        logic              tag_en;
        logic              tag_sys;
        logic [LINE_W-1:0] tag_line;
    } mcd_cmpl_t;

endpackage : mcd_pkg

`default_nettype wire

// >>> mcd_buf2.sv
// Two-entry buffer for transactions between the engine and the link.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none

module mcd_buf2
(
    input  wire logic           i_ref_clk,  // Core clock.
    input  wire logic           i_rstn,     // Synchronous reset, low.
    input  wire logic           i_valid,    // Filling side offers.
    output logic                o_ready,    // Room for one more.
    input  wire mcd_pkg::mcd_xfer_t i_data, // Word offered.
    output logic                o_valid,    // A word is held.
    input  wire logic           i_ready,    // Draining side takes.
    output mcd_pkg::mcd_xfer_t  o_data      // Oldest word, from flops.
);
    import mcd_pkg::*;

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        mcd_xfer_t [1:0] ent;  // Storage entries.
        logic [1:0]      cnt;  // Words held, zero to two.
        logic            rd;   // Entry read next.
    } mcd_buf_st_t;

    localparam logic [1:0] BUF_FULL = 2'h2;

    mcd_buf_st_t q;  // Registered state.
    mcd_buf_st_t d;  // Next state.
    logic        push;  // Word enters this cycle.
    logic        pop;   // Word leaves this cycle.

    assign o_ready = (q.cnt != BUF_FULL);
    assign o_valid = (q.cnt != 2'h0);
    assign o_data  = q.ent[q.rd];
    assign push    = i_valid && o_ready;
    assign pop     = o_valid && i_ready;

    // Two entries let the engine keep going for one cycle after the
    // receiver stalls, so no word is lost on the stall edge.
    always_comb
    begin
        d = q;
        if (push)
        begin
            d.ent[q.rd ^ q.cnt[0]] = i_data;
        end
        if (pop)
        begin
            d.rd = ~q.rd;
        end
        d.cnt = q.cnt + {1'b0, push} - {1'b0, pop};
    end

    // State register with synchronous reset.
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rstn)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rstn);

    // A held word stays until taken.
    hold_word_a: assert property (o_valid && !i_ready
        |=> o_valid && o_data == $past(o_data))
        else $error("buffered word changed while stalled");

    // A word that enters an empty buffer shows on the next cycle; the
    // receiver must never see a stale entry ahead of it.
    first_word_a: assert property (push && !o_valid
        |=> o_valid && o_data == $past(i_data))
        else $error("buffered word not shown in order");

endmodule : mcd_buf2

`default_nettype wire

// >>> mcd_far_model.sv
// Far side of the copy engine: descriptor memory and the data sink.
// Assumes one clock; drives its outputs 1 ns after each rising edge.
`timescale 1ns/100ps
`default_nettype none

module mcd_far_model
(
    input  wire logic                i_ref_clk,     // Core clock.
    input  wire logic                i_rstn,        // Sync reset, low.
    input  wire logic                i_slow,        // Answer every other cycle.
    input  wire mcd_pkg::mcd_desc_t [7:0] i_tab,    // Descriptor per channel.
    input  wire logic                i_fetch_valid, // Fetch offered.
    input  wire mcd_pkg::mcd_fetch_t i_fetch,       // Fetch request.
    output logic                     o_fetch_ready, // Fetch accepted.
    output logic                     o_desc_valid,  // Descriptor back.
    output mcd_pkg::mcd_desc_t       o_desc,        // Descriptor.
    input  wire logic                i_xfer_valid,  // Transaction offered.
    output logic                     o_xfer_ready   // Transaction taken.
);
    import mcd_pkg::*;

    logic             take_q;  // Fetch accepted at this edge.
    logic [CH_W-1:0]  ch_q;    // Channel of that fetch.
    logic             run_q;   // Reset level seen at this edge.
    logic             ph_q;    // Alternates to pace a slow answer.

    // One answer per edge; inputs are sampled before the delay so that
    // the model never reads what the engine launched at the same edge.
    initial
    begin
        {o_fetch_ready, o_desc_valid, o_xfer_ready, ph_q} = '0;
        o_desc = '0;
    end
    always @(posedge i_ref_clk)
    begin
        take_q = i_fetch_valid && o_fetch_ready;
        ch_q   = i_fetch.ch;
        run_q  = i_rstn;
        #1;
        ph_q          = ~ph_q;
        o_fetch_ready = run_q && (!i_slow || ph_q);
        o_xfer_ready  = run_q && (!i_slow || ph_q);
        o_desc_valid  = take_q;
        // A released bus shows the inverse of its last value, so a stale copy returns every other cycle.
        o_desc = take_q ? i_tab[ch_q] : ~o_desc;
    end
endmodule : mcd_far_model

`default_nettype wire

// >>> mcd_engine_tb_top.sv
// Self-checking bench of the copy engine against the far-side model.
// Assumes the engine's hand-over timing; runs on a 100 MHz clock.
`timescale 1ns/100ps
`default_nettype none

module mcd_engine_tb_top;
    import mcd_pkg::*;

    logic ref_clk, rstn, slow, fv, fr, dv, xv, xr;
    logic [1:0]                  pkt;   // Largest packet setting.
    logic [NUM_CH-1:0]           herr;  // Head error pulses.
    mcd_ring_cfg_t [NUM_CH-1:0]  cfg;   // Ring setup per channel.
    mcd_desc_t [NUM_CH-1:0]      tab;   // Descriptors the model returns.
    mcd_head_wr_t hw;
    mcd_fetch_t   fe;
    mcd_desc_t    de;
    mcd_xfer_t    xf;
    mcd_cmpl_t    cm;
    mcd_fetch_t   fq[$];  // Accepted fetches.
    mcd_xfer_t    xq[$];  // Accepted transactions.
    mcd_cmpl_t    cq[$];  // Completions.
    int err_count, check_count;

    mcd_engine dut (.i_ref_clk(ref_clk), .i_rstn(rstn), .i_ring_cfg(cfg),
        .i_pkt_len(pkt), .i_head_wr(hw), .o_fetch_valid(fv),
        .i_fetch_ready(fr), .o_fetch(fe), .i_desc_valid(dv), .i_desc(de),
        .o_xfer_valid(xv), .i_xfer_ready(xr), .o_xfer(xf), .o_cmpl(cm),
        .o_head_err(herr));
    mcd_far_model far (.i_ref_clk(ref_clk), .i_rstn(rstn), .i_slow(slow),
        .i_tab(tab), .i_fetch_valid(fv), .i_fetch(fe), .o_fetch_ready(fr),
        .o_desc_valid(dv), .o_desc(de), .i_xfer_valid(xv),
        .o_xfer_ready(xr));

    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // Record every completed handshake at the edge that takes it.
    always @(posedge ref_clk)
    begin
        if (fv === 1'b1 && fr === 1'b1) fq.push_back(fe);
        if (xv === 1'b1 && xr === 1'b1) xq.push_back(xf);
        if (cm.valid === 1'b1) cq.push_back(cm);
    end

    task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            err_count++;
            $display("CHECK FAILED at %0t seen %h exp %h", $time, seen, exp);
        end
    endtask : chk

    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : complete_run

    // Bounded wait for n completions, then let the pipeline drain.
    task automatic wait_cmpl(input int n);
        for (int i = 0; i < 3000 && cq.size() < n; i++) @(posedge ref_clk);
        if (cq.size() < n)
        begin
            chk(cq.size(), n);
            complete_run();
        end
        else
        begin
            repeat (4) @(posedge ref_clk);
            #1;
        end
    endtask : wait_cmpl

    // One head write; leaves the strobe low for the next cycle.
    task automatic head(input int ch, input int idx);
        hw = '{1'b1, ch[CH_W-1:0], idx[IDX_W-1:0]};
        @(posedge ref_clk);
        #1;
        hw.valid = 1'b0;
    endtask : head

    // Out-of-range head writes, then seven empty descriptors in order.
    task automatic t_head();
        fq.delete(); cq.delete();
        head(2, 8);
        chk(herr, 8'h04);
        @(posedge ref_clk);
        #1;
        chk(herr, 8'h00);
        head(5, 0);
        chk(herr, 8'h20);
        @(posedge ref_clk);
        #1;
        head(2, 7);
        chk(herr, 8'h00);
        wait_cmpl(7);
        // Fetches must walk the ring one entry at a time from its base.
        for (int i = 0; i < 7; i++)
        begin
            chk(cq[i].ch, 3'h2);
            chk(fq[i], {3'h2, cfg[2].base + 40'(i * 16), 1'b0});
        end
        $display("test head_range done");
    endtask : t_head

    // Five lines per descriptor under every packet setting and direction.
    task automatic t_split();
        mcd_xfer_t e;
        int mx, pc, n, rem;
        for (int k = 0; k < 4; k++)
        begin
            fq.delete(); xq.delete(); cq.delete();
            pkt = k[1:0];
            slow = k[0];
            tab[0].dir = mcd_dir_t'(k % 3);
            head(0, k + 1);
            wait_cmpl(1);
            chk(fq[0], {3'h0, cfg[0].base + 40'(k * 16), 1'b1});
            mx = (k == 0) ? 1 : (k == 1) ? 2 : 4;
            e = '{3'h0, tab[0].dir, tab[0].src, tab[0].dst, 3'h0};
            n = 0;
            for (rem = 5; rem > 0; rem -= pc)
            begin
                pc = (rem < mx) ? rem : mx;
                e.lines = pc[CHUNK_W-1:0];
                chk(xq[n], e);
                e.src = e.src + LINE_W'(pc);
                e.dst = e.dst + LINE_W'(pc);
                n++;
            end
            chk(xq.size(), n);
            chk(cq[0], {4'h8, 3'h7, 34'h777});
        end
        $display("test split done");
    endtask : t_split

    // Two local rings loaded back to back must take turns.
    task automatic t_rr();
        fq.delete(); cq.delete();
        pkt = 2'h2;
        slow = 1'b0;
        hw = '{1'b1, 3'h1, 17'h2};
        @(posedge ref_clk);
        #1;
        hw = '{1'b1, 3'h3, 17'h2};
        @(posedge ref_clk);
        #1;
        hw.valid = 1'b0;
        wait_cmpl(4);
        chk(fq[0].sys, 1'b0);
        chk(cq[0].ch, 3'h1);
        // Channel 1 was granted first, so the turns go 1, 3, 1, 3.
        for (int i = 1; i < 4; i++)
        begin
            chk(cq[i].ch, (i % 2 == 1) ? 3'h3 : 3'h1);
        end
        $display("test round_robin done");
    endtask : t_rr

    initial
    begin
        {rstn, slow, err_count, check_count} = '0;
        pkt = 2'h2;
        hw = '0;
        cfg = '0;
        cfg[0] = '{40'h80_0000_1000, 17'h10};
        cfg[1] = '{40'h00_0000_2000, 17'h4};
        cfg[2] = '{40'h00_0000_3000, 17'h8};
        cfg[3] = '{40'h00_0000_4000, 17'h4};
        tab = '0;
        tab[0] = '{34'h100, 34'h2000, 20'h5, MCD_DIR_L2H, 1'b1, 1'b1,
            1'b1, 34'h777};
        tab[1] = '{34'h300, 34'h400, 20'h1, MCD_DIR_L2L, 1'b0, 1'b0,
            1'b0, 34'h0};
        tab[3] = tab[1];
        repeat (12) @(posedge ref_clk);
        #1;
        rstn = 1'b1;
        // One quiet edge after release before the first request.
        @(posedge ref_clk);
        #1;
        t_head();
        t_split();
        t_rr();
        complete_run();
    end
endmodule : mcd_engine_tb_top

`default_nettype wire
